// ---- rtl/eaf_aggregate_formatter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "eaf_defs.svh"

module eaf_fifo #(
    parameter int W = 32,
    parameter int D = 32
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    generate
        if (D < 2 || D != (1 << AW))
        begin : g_bad
            $error("Depth must be a power of two");
        end
    endgenerate

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;

    wire push = ce && in_valid && in_ready;
    wire load = ce && (cnt != '0) && (!out_valid || out_ready);

    assign in_ready = (cnt != D[AW:0]);

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wp        <= '0;
            rp        <= '0;
            cnt       <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else if (ce)
        begin
            if (push)
                wp <= wp + 1'b1;
            if (load)
            begin
                rp       <= rp + 1'b1;
                out_data <= mem[rp];
            end
            cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
            if (load)
                out_valid <= 1'b1;
            else if (out_ready)
                out_valid <= 1'b0;
        end
    end

endmodule : eaf_fifo

// Operation
// - Buffer count is two to exponent
// - Events per buffer limited to 1023
// - Adjacent channel pairs share one buffer
// - Samples per event are length times eight
// - Memory locations are 128 bits wide
// - Time stamp location plus energy/extras location
// - One extra location per eight samples
// - Channel bit: 0 odd, 1 even
// - List mode event uses two locations
// - Buffer withheld from readout until full
// - Aggregate carries programmed event count
// - Format flag set means format word follows
// - Format word reports dual trace flag
// - Format word reports presence flags
// - Layout 000: extended stamp and baseline
// - Layout 100: lost and total counters
// - Layout 010: extended and fine stamp
// - Layout 101: zero crossing neighbours
// - Second extras only when config bit17
// - Primary analog probe trace select
// - Secondary analog probe trace select
// - Digital probe codes zero to five
// - Digital probe codes six to twelve
module eaf_aggregate_formatter #(
    parameter int LOG_MEM = 10,
    parameter int NB_MAX  = 4,
    parameter int FIFO_D  = 32
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    input  wire eaf_pkg::eaf_reg_req_t reg_req,
    output logic [31:0]                reg_rdata,
    output logic                       reg_rvalid,
    input  wire eaf_pkg::eaf_event_t   ev_in,
    input  wire logic                  ev_valid,
    output logic                       ev_ready,
    input  wire eaf_pkg::eaf_trace_t   trace_in,
    input  wire logic                  samp_valid,
    output logic                       samp_ready,
    output logic [31:0]                agg_word,
    output logic                       agg_valid,
    input  wire logic                  agg_ready
);
    localparam int NBUF = 1 << NB_MAX;
    localparam int NBW  = $clog2(NB_MAX + 1);

    generate
        if (NB_MAX < 1 || NB_MAX > 4 || NB_MAX > LOG_MEM || LOG_MEM > 16)
        begin : g_bad
            $error("Unsupported memory shape");
        end
    endgenerate

    logic [31:0]         board_cfg;
    logic [NBW-1:0]      nb;
    logic [15:0]         ns;
    logic [9:0]          ne;
    logic [`EAF_LOC_BITS-1:0] mem [1 << LOG_MEM];
    eaf_pkg::eaf_wstate_t wstate;
    eaf_pkg::eaf_wstate_t next_wstate;
    eaf_pkg::eaf_rstate_t rstate;
    eaf_pkg::eaf_rstate_t next_rstate;
    eaf_pkg::eaf_event_t  ev_q;
    logic [NB_MAX-1:0]   wbuf;
    logic [NB_MAX-1:0]   rbuf;
    logic [LOG_MEM-1:0]  wptr;
    logic [LOG_MEM-1:0]  rptr;
    logic [9:0]          ev_cnt;
    logic [9:0]          rev;
    logic [15:0]         loc_cnt;
    logic [15:0]         rloc;
    logic [15:0]         ev_locs;
    logic [2:0]          scnt;
    logic [1:0]          rword;
    logic [111:0]        pack;
    logic [127:0]        mem_q;
    logic [NBUF-1:0]     ready_mask;
    logic                fifo_rdy;

    // Register decode
    wire [31:0] wd     = reg_req.wdata;
    wire        wr_cfg = ce && reg_req.wr && reg_req.addr == `EAF_ADDR_CFG;
    wire        wr_org = ce && reg_req.wr && reg_req.addr == `EAF_ADDR_ORG;
    wire        wr_len = ce && reg_req.wr && reg_req.addr == `EAF_ADDR_RLEN;
    wire        wr_ne  = ce && reg_req.wr && reg_req.addr == `EAF_ADDR_NE;
    wire [NBW-1:0] nb_wr = (wd > 32'(NB_MAX)) ? NBW'(NB_MAX) : wd[NBW-1:0];

    // Configuration fields
    wire       dt   = board_cfg[`EAF_CFG_DUAL];
    wire       wave = board_cfg[`EAF_CFG_WAVE];
    wire       aux  = board_cfg[`EAF_CFG_AUX];
    wire       fi   = board_cfg[`EAF_CFG_FI];
    wire [2:0] lay  = board_cfg[`EAF_CFG_LAYOUT];
    wire [1:0] ap1  = board_cfg[`EAF_CFG_AP1];
    wire [1:0] ap2  = board_cfg[`EAF_CFG_AP2];
    wire [3:0] dp   = board_cfg[`EAF_CFG_DP];
    wire [15:0] ns_eff = (wave && ns != 16'h0000) ? ns : 16'h0000;
    wire [9:0]  ne_eff = (ne == 10'h000) ? 10'h001 : ne;
    wire [NB_MAX-1:0] buf_mask = NB_MAX'((1 << nb) - 1);
    wire [4:0]  shift  = 5'(LOG_MEM) - 5'(nb);

    // Probe selection
    wire [13:0] ap1_v = trace_in.ap1_src[ap1];
    wire [13:0] ap2_v = trace_in.ap2_src[ap2];
    wire        dig_v = (dp == 4'h4) ? trace_in.dig_src[0] :
                        (dp <= 4'hc) ? trace_in.dig_src[dp] : 1'b0;
    wire [15:0] samp  = {dig_v, trace_in.trig, (dt && scnt[0]) ? ap2_v : ap1_v};

    // Second extras word
    wire [15:0] ext_ts = ev_q.time_stamp[46:31];
    wire [31:0] aux2 =
        !aux ? 32'h0000_0000 :
        (lay == `EAF_LAY_EXTTS_BL) ? {ext_ts, ev_q.baseline[13:0], 2'b00} :
        (lay == `EAF_LAY_FINE) ? {ext_ts, 6'h00, ev_q.fine_ts} :
        (lay == `EAF_LAY_TRGCNT) ? {ev_q.lost_trg, ev_q.total_trg} :
        (lay == `EAF_LAY_ZC) ? {ev_q.zc_before, ev_q.zc_after} :
        32'h0000_0000;

    // Writer
    wire ev_take   = ce && ev_valid && ev_ready;
    wire samp_take = ce && samp_valid && samp_ready;
    wire samp_last = samp_take && scnt == 3'h7 && loc_cnt == ns_eff - 16'h0001;
    wire ev_last   = (wstate == eaf_pkg::w_en) && ev_cnt == ne_eff - 10'h001;
    wire we = ce && (wstate == eaf_pkg::w_ts || wstate == eaf_pkg::w_en ||
                     (wstate == eaf_pkg::w_samp && samp_take && scnt == 3'h7));
    wire [127:0] wdata =
        (wstate == eaf_pkg::w_ts) ?
            {96'h0, ~ev_q.chan_odd, ev_q.time_stamp[30:0]} :
        (wstate == eaf_pkg::w_samp) ? {samp, pack} :
        {64'h0, aux2, ev_q.extras, ev_q.energy};
    wire [LOG_MEM-1:0] waddr = (LOG_MEM'(wbuf) << shift) + wptr;
    wire [NB_MAX-1:0]  next_wbuf = ev_last ? (wbuf + 1'b1) & buf_mask : wbuf;

    // Reader
    wire        is_ts    = rloc == 16'h0000;
    wire        is_en    = rloc == ns_eff + 16'h0001;
    wire [1:0]  nwm1     = is_ts ? 2'h0 : is_en ? {1'b0, aux} : 2'h3;
    wire [31:0] loc_word = mem_q[32 * rword +: 32];
    wire [31:0] fmt_word = {dt, board_cfg[`EAF_CFG_EN_ON], board_cfg[`EAF_CFG_TS_ON],
                            aux, wave, lay, ap1, ap2, dp, ns};
    wire [27:0] per_ev   = 28'(ns_eff) * 28'h000_0004 + 28'h000_0002 + 28'(aux);
    wire [27:0] agg_size = 28'(ne_eff) * per_ev + (fi ? 28'h000_0002 : 28'h000_0001);
    wire [31:0] hdr_word = {fi, 3'b000, agg_size};
    wire        push     = ce && (rstate == eaf_pkg::r_hdr || rstate == eaf_pkg::r_fmt ||
                                  rstate == eaf_pkg::r_words);
    wire [31:0] push_word = (rstate == eaf_pkg::r_hdr) ? hdr_word :
                            (rstate == eaf_pkg::r_fmt) ? fmt_word : loc_word;
    wire        adv      = push && fifo_rdy;
    wire        loc_done = rstate == eaf_pkg::r_words && adv && rword == nwm1;
    wire        ev_done  = loc_done && is_en;
    wire        rd_done  = ev_done && rev == ne_eff - 10'h001;
    wire [LOG_MEM-1:0] raddr = (LOG_MEM'(rbuf) << shift) + rptr;

    wire [NBUF-1:0] clr_bit = rd_done ? NBUF'(1) << rbuf : '0;
    wire [NBUF-1:0] set_bit = ev_last ? NBUF'(1) << wbuf : '0;
    wire [NBUF-1:0] next_ready = (ready_mask & ~clr_bit) | set_bit;

    wire [31:0] status = {16'(ready_mask), 8'(wbuf), 8'(rbuf)};
    wire [15:0] ra     = reg_req.addr;
    wire [31:0] rd_mux = (ra == `EAF_ADDR_CFG) ? board_cfg :
                         (ra == `EAF_ADDR_ORG) ? 32'(nb) :
                         (ra == `EAF_ADDR_RLEN) ? {16'h0000, ns} :
                         (ra == `EAF_ADDR_NE) ? 32'(ne) :
                         (ra == `EAF_ADDR_STATUS) ? status : 32'h0000_0000;

    always_comb
    begin
        unique case (wstate)
            eaf_pkg::w_idle: next_wstate = ev_take ? eaf_pkg::w_ts : eaf_pkg::w_idle;
            eaf_pkg::w_ts:   next_wstate = (ns_eff != 16'h0000) ? eaf_pkg::w_samp
                                                                : eaf_pkg::w_en;
            eaf_pkg::w_samp: next_wstate = samp_last ? eaf_pkg::w_en : eaf_pkg::w_samp;
            eaf_pkg::w_en:   next_wstate = eaf_pkg::w_idle;
            default:         next_wstate = eaf_pkg::w_idle;
        endcase
    end

    always_comb
    begin
        unique case (rstate)
            eaf_pkg::r_idle:  next_rstate = ready_mask[rbuf] ? eaf_pkg::r_hdr
                                                             : eaf_pkg::r_idle;
            eaf_pkg::r_hdr:   next_rstate = !adv ? eaf_pkg::r_hdr :
                                            fi ? eaf_pkg::r_fmt : eaf_pkg::r_fetch;
            eaf_pkg::r_fmt:   next_rstate = adv ? eaf_pkg::r_fetch : eaf_pkg::r_fmt;
            eaf_pkg::r_fetch: next_rstate = eaf_pkg::r_words;
            eaf_pkg::r_words: next_rstate = rd_done ? eaf_pkg::r_idle :
                                            loc_done ? eaf_pkg::r_fetch : eaf_pkg::r_words;
            default:          next_rstate = eaf_pkg::r_idle;
        endcase
    end

    // Registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            board_cfg <= `EAF_CFG_RST;
            nb        <= NBW'(`EAF_ORG_RST);
            ns        <= 16'(`EAF_RLEN_RST);
            ne        <= 10'(`EAF_NE_RST);
        end
        else
        begin
            if (wr_cfg)
                board_cfg <= wd;
            if (wr_org)
                nb <= nb_wr;
            if (wr_len)
                ns <= wd[15:0];
            if (wr_ne)
                ne <= wd[9:0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            reg_rvalid <= 1'b0;
            reg_rdata  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            reg_rvalid <= reg_req.rd;
            reg_rdata  <= reg_req.rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Event memory
    always_ff @(posedge core_clk)
    begin
        if (we)
            mem[waddr] <= wdata;
        if (ce && rstate == eaf_pkg::r_fetch)
            mem_q <= mem[raddr];
        if (ev_take)
            ev_q <= ev_in;
    end

    // Writer state
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wstate     <= eaf_pkg::w_idle;
            wbuf       <= '0;
            ready_mask <= '0;
            ev_ready   <= 1'b0;
            samp_ready <= 1'b0;
        end
        else if (ce)
        begin
            wstate     <= next_wstate;
            wbuf       <= next_wbuf;
            ready_mask <= next_ready;
            ev_ready   <= next_wstate == eaf_pkg::w_idle && !next_ready[next_wbuf];
            samp_ready <= next_wstate == eaf_pkg::w_samp;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wptr    <= '0;
            ev_cnt  <= '0;
            loc_cnt <= '0;
            scnt    <= '0;
            pack    <= '0;
            ev_locs <= '0;
        end
        else if (ce)
        begin
            if (we)
                wptr <= ev_last ? '0 : wptr + 1'b1;
            if (wstate == eaf_pkg::w_en)
                ev_cnt <= ev_last ? 10'h000 : ev_cnt + 10'h001;
            if (samp_take)
            begin
                scnt <= scnt + 3'h1;
                pack <= {samp, pack[111:16]};
            end
            if (samp_take && scnt == 3'h7)
                loc_cnt <= samp_last ? 16'h0000 : loc_cnt + 16'h0001;
            if (ev_take)
                ev_locs <= 16'h0000;
            else if (we)
                ev_locs <= ev_locs + 16'h0001;
        end
    end

    // Reader state
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rstate <= eaf_pkg::r_idle;
            rbuf   <= '0;
            rptr   <= '0;
            rloc   <= '0;
            rev    <= '0;
            rword  <= '0;
        end
        else if (ce)
        begin
            rstate <= next_rstate;
            if (rstate == eaf_pkg::r_fetch)
                rword <= 2'h0;
            else if (rstate == eaf_pkg::r_words && adv)
                rword <= rword + 2'h1;
            if (loc_done)
            begin
                rptr <= rd_done ? '0 : rptr + 1'b1;
                rloc <= is_en ? 16'h0000 : rloc + 16'h0001;
            end
            if (ev_done)
                rev <= rd_done ? 10'h000 : rev + 10'h001;
            if (rd_done)
                rbuf <= (rbuf + 1'b1) & buf_mask;
        end
    end

    eaf_fifo #(
        .W (32),
        .D (FIFO_D)
    ) u_fifo (
        .clk       (core_clk),
        .rst       (rst),
        .ce        (ce),
        .in_data   (push_word),
        .in_valid  (push),
        .in_ready  (fifo_rdy),
        .out_data  (agg_word),
        .out_valid (agg_valid),
        .out_ready (agg_ready)
    );

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst || !ce);

    sequence hdr_push_s;
        rstate == eaf_pkg::r_hdr && adv;
    endsequence

    sequence ev_start_s;
        ev_take ##1 wstate == eaf_pkg::w_ts;
    endsequence

    buf_range_a: assert property (
        (wbuf & ~buf_mask) == '0 && (rbuf & ~buf_mask) == '0)
        else $error("Buffer index beyond programmed count");
    ne_write_a: assert property (
        wr_ne |=> ne == $past(wd[9:0]))
        else $error("Event count register not updated");
    pair_bit_a: assert property (
        ev_start_s |-> we && wdata[31] == !ev_q.chan_odd)
        else $error("Channel bit wrong in time stamp location");
    ev_locs_a: assert property (
        wstate == eaf_pkg::w_en |-> ev_locs == ns_eff + 16'h0001)
        else $error("Event location count wrong");
    withhold_a: assert property (
        rstate == eaf_pkg::r_idle && !ready_mask[rbuf] |=> rstate == eaf_pkg::r_idle)
        else $error("Readout of incomplete buffer");
    agg_done_a: assert property (
        rd_done |=> !ready_mask[$past(rbuf)] && rstate == eaf_pkg::r_idle)
        else $error("Aggregate end not handled");
    fmt_order_a: assert property (
        hdr_push_s |=> (rstate == eaf_pkg::r_fmt) == $past(fi))
        else $error("Format word order wrong");
    ext_ts_a: assert property (
        wstate == eaf_pkg::w_en && aux && lay == `EAF_LAY_EXTTS_BL
        |-> wdata[63:48] == ev_q.time_stamp[46:31])
        else $error("Extended stamp misplaced");
    trg_cnt_a: assert property (
        wstate == eaf_pkg::w_en && aux && lay == `EAF_LAY_TRGCNT
        |-> wdata[63:32] == {ev_q.lost_trg, ev_q.total_trg})
        else $error("Trigger counters misplaced");
    aux_gate_a: assert property (
        rstate == eaf_pkg::r_words && is_en && !aux && adv |=> rstate != eaf_pkg::r_words)
        else $error("Second extras emitted while off");
    dig_alias_a: assert property (
        we && wstate == eaf_pkg::w_samp && dp == 4'h4
        |-> wdata[127] == trace_in.dig_src[0])
        else $error("Digital probe alias wrong");

endmodule : eaf_aggregate_formatter

`default_nettype wire

// ---- rtl/eaf_defs.svh ----
`ifndef EAF_DEFS_SVH
`define EAF_DEFS_SVH

// Register offsets
`define EAF_ADDR_CFG      16'h8000
`define EAF_ADDR_ORG      16'h800c
`define EAF_ADDR_RLEN     16'h8020
`define EAF_ADDR_NE       16'h1034
`define EAF_ADDR_STATUS   16'h8104

// Board configuration fields
`define EAF_CFG_LAYOUT    10:8
`define EAF_CFG_DUAL      11
`define EAF_CFG_AP1       13:12
`define EAF_CFG_AP2       15:14
`define EAF_CFG_WAVE      16
`define EAF_CFG_AUX       17
`define EAF_CFG_TS_ON     18
`define EAF_CFG_EN_ON     19
`define EAF_CFG_DP        23:20
`define EAF_CFG_FI        24

// Reset values
`define EAF_CFG_RST       32'h010c_0000
`define EAF_ORG_RST       32'h0000_0000
`define EAF_RLEN_RST      32'h0000_0001
`define EAF_NE_RST        32'h0000_0001

// Second extras word layouts
`define EAF_LAY_EXTTS_BL  3'h0
`define EAF_LAY_FINE      3'h2
`define EAF_LAY_TRGCNT    3'h4
`define EAF_LAY_ZC        3'h5

// Sizes
`define EAF_SAMP_PER_LOC  8
`define EAF_NE_MAX        1023
`define EAF_LOC_BITS      128

`endif

// ---- rtl/eaf_pkg.sv ----
package eaf_pkg;

    typedef struct packed {
        logic        chan_odd;
        logic [46:0] time_stamp;
        logic [15:0] energy;
        logic [15:0] extras;
        logic [15:0] baseline;
        logic [15:0] lost_trg;
        logic [15:0] total_trg;
        logic [9:0]  fine_ts;
        logic [15:0] zc_before;
        logic [15:0] zc_after;
    } eaf_event_t;

    typedef struct packed {
        logic [3:0][13:0] ap1_src;
        logic [3:0][13:0] ap2_src;
        logic [12:0]      dig_src;
        logic             trig;
    } eaf_trace_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } eaf_reg_req_t;

    typedef enum logic [3:0] {
        w_idle = 4'b0001, w_ts = 4'b0010, w_samp = 4'b0100, w_en = 4'b1000
    } eaf_wstate_t;

    typedef enum logic [4:0] {
        r_idle = 5'b00001, r_hdr = 5'b00010, r_fmt = 5'b00100,
        r_fetch = 5'b01000, r_words = 5'b10000
    } eaf_rstate_t;

endpackage : eaf_pkg

// ---- sim/eaf_aggregate_formatter_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "eaf_defs.svh"
module eaf_aggregate_formatter_test;
    logic                  core_clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  ce = 1'b1;
    logic                  ev_valid = 1'b0;
    logic                  samp_valid = 1'b0;
    logic                  slow = 1'b0;
    logic                  reg_rvalid, ev_ready, samp_ready, agg_valid, agg_ready;
    logic [31:0]           reg_rdata, agg_word;
    eaf_pkg::eaf_reg_req_t rq = '0;
    eaf_pkg::eaf_event_t   ev = '0;
    eaf_pkg::eaf_trace_t   tr = '0;
    logic [31:0]           qr[$], qa[$];
    int                    error_cnt = 0, checked = 0, cyc = 0, ns, ne;
    logic                  fi, aux, wav, dt;
    logic [2:0]            lay;
    logic [1:0]            a1, a2;
    logic [3:0]            dp;

    always #2.5 core_clk = ~core_clk;

    eaf_aggregate_formatter dut_u (
        .core_clk(core_clk), .rst(rst), .ce(ce), .reg_req(rq), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .ev_in(ev), .ev_valid(ev_valid), .ev_ready(ev_ready),
        .trace_in(tr), .samp_valid(samp_valid), .samp_ready(samp_ready),
        .agg_word(agg_word), .agg_valid(agg_valid), .agg_ready(agg_ready));

    eaf_readout_model rdo_u (.core_clk(core_clk), .slow(slow), .agg_ready(agg_ready));

    task automatic results();
        $display("mismatches %0d of %0d compares", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Watcher: each result takes the oldest note off its queue
    always @(posedge core_clk)
    begin
        cyc++;
        if (reg_rvalid === 1'b1)
            cmp(reg_rdata, qr.size() ? qr.pop_front() : 32'hdead_beef);
        if (!rst && agg_valid === 1'b1 && agg_ready === 1'b1)
            cmp(agg_word, qa.size() ? qa.pop_front() : 32'hdead_beef);
        if (cyc == 40000)
        begin
            error_cnt++;
            results();
        end
    end

    task automatic rg(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(negedge core_clk);
        rq = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge core_clk);
        rq = '0;
    endtask : rg

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        qr.push_back(e);
        rg(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic setup(input logic f, x, w, d, input logic [2:0] l, input logic [3:0] p,
                         input int n, input int e);
        fi = f; aux = x; wav = w; dt = d; lay = l; dp = p; ns = n; ne = e;
        a1 = p[1:0]; a2 = p[3:2];
        rg(1'b1, `EAF_ADDR_CFG, {7'h00, f, p, 2'b11, x, w, a2, a1, d, l, 8'h00});
        rg(1'b1, `EAF_ADDR_RLEN, 32'(n));
        rg(1'b1, `EAF_ADDR_NE, 32'(e));
    endtask : setup

    function automatic logic [31:0] x2();
        case (lay)
            3'h0: return {ev.time_stamp[46:31], ev.baseline[13:0], 2'b00};
            3'h2: return {ev.time_stamp[46:31], 6'h00, ev.fine_ts};
            3'h4: return {ev.lost_trg, ev.total_trg};
            3'h5: return {ev.zc_before, ev.zc_after};
            default: return 32'h0000_0000;
        endcase
    endfunction : x2

    task automatic send(input int nse);
        int k;
        ev_valid = 1'b1;
        for (k = 0; k < 2000; k++)
        begin
            @(posedge core_clk);
            if (ev_ready === 1'b1) break;
        end
        @(negedge core_clk);
        ev_valid = 1'b0;
        if (nse > 0)
        begin
            samp_valid = 1'b1;
            for (k = 0; k < nse * 8;)
            begin
                @(posedge core_clk);
                if (samp_ready === 1'b1) k++;
            end
            @(negedge core_clk);
            samp_valid = 1'b0;
        end
    endtask : send

    task automatic agg(input bit chk);
        logic [191:0] r;
        logic [15:0]  s1, s2;
        logic         dg;
        int           nse;
        nse = wav ? ns : 0;
        qa.push_back({fi, 3'b000, 28'(ne * (2 + 4 * nse + aux) + (fi ? 2 : 1))});
        if (fi) qa.push_back({dt, 2'b11, aux, wav, lay, a1, a2, dp, 16'(ns)});
        for (int i = 0; i < ne; i++)
        begin
            @(negedge core_clk);
            r = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
            ev = r[169:0];
            r = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
            tr = r[125:0];
            dg = (dp == 4'h4) ? tr.dig_src[0] :
                 (dp <= 4'hc) ? tr.dig_src[dp] : 1'b0;
            s1 = {dg, tr.trig, tr.ap1_src[a1]};
            s2 = dt ? {dg, tr.trig, tr.ap2_src[a2]} : s1;
            qa.push_back({~ev.chan_odd, ev.time_stamp[30:0]});
            repeat (nse * 4) qa.push_back({s2, s1});
            qa.push_back({ev.extras, ev.energy});
            if (aux) qa.push_back(x2());
            send(nse);
            if (chk && i < ne - 1) repeat (8) @(negedge core_clk) cmp({31'h0, agg_valid}, 0);
        end
    endtask : agg

    task automatic drain(input string nm);
        for (int k = 0; k < 4000 && qa.size() > 0; k++) @(posedge core_clk);
        repeat (4) @(negedge core_clk);
        cmp(32'(qa.size() + qr.size()), 32'h0000_0000);
        $display("test %s done", nm);
    endtask : drain

    initial
    begin
        void'($urandom(46));
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        rd(`EAF_ADDR_CFG, `EAF_CFG_RST);
        rd(`EAF_ADDR_ORG, `EAF_ORG_RST);
        rd(`EAF_ADDR_RLEN, `EAF_RLEN_RST);
        rd(`EAF_ADDR_NE, `EAF_NE_RST);
        rd(16'h8010, 32'h0000_0000);
        rg(1'b1, `EAF_ADDR_ORG, 32'h0000_0007);
        rd(`EAF_ADDR_ORG, 32'h0000_0004);
        rg(1'b1, `EAF_ADDR_NE, 32'h0000_07ff);
        rd(`EAF_ADDR_NE, 32'h0000_03ff);
        rg(1'b1, `EAF_ADDR_ORG, 32'h0000_0001);
        drain("registers");
        for (int l = 0; l < 8; l++)
        begin
            setup(1'b1, 1'b1, 1'b0, 1'b0, 3'(l), 4'h0, 1, 2);
            agg(1'b1);
            drain("extras layout");
        end
        slow = 1'b1;
        setup(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 4'h0, 1, 8);
        repeat (4) agg(1'b0);
        drain("stalled list mode");
        slow = 1'b0;
        for (int k = 0; k < 16; k++)
        begin
            setup(1'b1, 1'b0, 1'b1, k[0], 3'h0, 4'(k), 1, 1);
            agg(1'b0);
            drain("waveform probes");
        end
        setup(1'b1, 1'b1, 1'b1, 1'b1, 3'h2, 4'h5, 0, 1);
        agg(1'b0);
        drain("zero length");
        results();
    end
endmodule : eaf_aggregate_formatter_test
`default_nettype wire

// ---- sim/eaf_readout_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module eaf_readout_model (
    input  wire logic core_clk,
    input  wire logic slow,
    output var logic  agg_ready
);
    // Readout controller: takes words at full rate, or stalls most cycles when slow
    initial agg_ready = 1'b0;
    always @(negedge core_clk)
        agg_ready <= slow ? ($urandom_range(7) == 0) : 1'b1;
endmodule : eaf_readout_model
`default_nettype wire
